/* src/sda_regs.sv */
`default_nettype none
// Function
// RULE1: done reads 1 only when enabled and finished
// RULE2: result field valid only while done
// RULE3: result top bit flags clock inversion
// RULE4: coarse in 15:8, fine in 7:0
// RULE5: invert bit inverts sampling clock
// RULE6: manual coarse sets delay when disabled
// RULE7: manual fine sets delay when disabled
// RULE8: software stops cal and link before invert
// RULE9: coarse steps at most four while running
// RULE10: single coarse code per write recommended
// RULE11: fine writes take effect at once
// RULE12: step limit via small writes or ramp
// RULE13: calibration overrides manual register when enabled
// RULE14: slow ramp moves one code per 384
// RULE15: reserved bits read zero, ignore writes
module sda_regs #(
  parameter int RAMP_CYC = sda_pkg::SDA_RAMP_STEP_CYC
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rstn,
  // register access
  input  wire sda_pkg::sda_req_t    req,
  output var  logic [23:0]          rdata,
  // calibration engine
  input  wire logic                 cal_finished,
  input  wire sda_pkg::sda_delay_t  cal_result,
  // applied delay to sampling clock path
  output var  sda_pkg::sda_delay_t  applied_delay,
  output var  logic                 sync_cal_enable
);
  logic [23:0]         ctrl_reg, ctrl_next;
  logic                en_reg, en_next;
  logic [1:0]          ramp_reg, ramp_next;
  logic                done_reg, done_next;
  logic [16:0]         result_reg, result_next;
  logic [7:0]          crs_reg, crs_next;
  logic [8:0]          tick_reg, tick_next;
  sda_pkg::sda_delay_t app_next;
  logic [23:0]         rd_next;
  logic [7:0]          tgt;
  logic [7:0]          step;

  assign tgt  = ctrl_reg[sda_pkg::SDA_CRS_LSB +: sda_pkg::SDA_CRS_W];
  assign step = ramp_reg[1] ? sda_pkg::SDA_RAMP_FAST : sda_pkg::SDA_RAMP_SLOW;

  // register writes, calibration status and coarse ramp
  always_comb begin
    ctrl_next   = ctrl_reg;
    en_next     = en_reg;
    ramp_next   = ramp_reg;
    done_next   = done_reg;
    result_next = result_reg;
    crs_next    = crs_reg;
    tick_next   = tick_reg;
    if (req.wr) begin
      if (req.addr == sda_pkg::SDA_ADDR_DELAY_CTRL)
        ctrl_next = req.wdata & sda_pkg::SDA_CTRL_MASK; // see RULE15
      if (req.addr == sda_pkg::SDA_ADDR_CAL_ENABLE)
        en_next = req.wdata[0];
      if (req.addr == sda_pkg::SDA_ADDR_RAMP_CTRL)
        ramp_next = req.wdata[1:0];
    end
    // a new enable edge restarts calibration, so stale done is dropped;
    // a disabling write clears done at once, even against a late finish
    if (!en_reg || !en_next) begin
      done_next = 1'b0; // see RULE1
    end else if (cal_finished) begin
      done_next   = 1'b1; // see RULE1
      result_next = cal_result; // see RULE3 see RULE4
    end
    // coarse tracking: abrupt without ramp, stepped with ramp
    // ramp ticks count system clocks standing in for sampling clocks
    if (!ramp_reg[0]) begin
      crs_next  = tgt;
      tick_next = '0;
    end else if (crs_reg == tgt) begin
      tick_next = '0;
    end else if (tick_reg == 9'(RAMP_CYC - 1)) begin
      tick_next = '0;
      if (crs_reg < tgt)
        crs_next = (tgt - crs_reg < step) ? tgt : 8'(crs_reg + step); // see RULE14
      else
        crs_next = (crs_reg - tgt < step) ? tgt : 8'(crs_reg - step); // see RULE14
    end else begin
      tick_next = 9'(tick_reg + 9'h001);
    end
  end

  // applied delay selection
  // with calibration on, a stale result drives the path until done rises
  always_comb begin
    if (en_reg) begin
      app_next = result_reg; // see RULE13
    end else begin
      app_next.invert = ctrl_reg[sda_pkg::SDA_INV_BIT]; // see RULE5
      app_next.coarse = crs_reg; // see RULE6
      app_next.fine   = ctrl_reg[sda_pkg::SDA_FINE_W-1:0]; // see RULE7 see RULE11
    end
  end

  // read data mux, unmapped reads zero
  always_comb begin
    rd_next = 24'h000000;
    if (req.rd) begin
      case (req.addr)
        sda_pkg::SDA_ADDR_DELAY_CTRL: rd_next = ctrl_reg;
        sda_pkg::SDA_ADDR_CAL_STATUS: rd_next = {6'h00, done_reg, result_reg}; // see RULE2
        sda_pkg::SDA_ADDR_CAL_ENABLE: rd_next = {23'h000000, en_reg};
        sda_pkg::SDA_ADDR_RAMP_CTRL:  rd_next = {22'h000000, ramp_reg};
        default:                      rd_next = 24'h000000;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg        <= sda_pkg::SDA_CTRL_RST;
      en_reg          <= 1'b0;
      ramp_reg        <= 2'h0;
      done_reg        <= 1'b0;
      result_reg      <= 17'h00000;
      crs_reg         <= 8'h00;
      tick_reg        <= 9'h000;
      applied_delay   <= '0;
      rdata           <= 24'h000000;
      sync_cal_enable <= 1'b0;
    end else begin
      ctrl_reg        <= ctrl_next;
      en_reg          <= en_next;
      ramp_reg        <= ramp_next;
      done_reg        <= done_next;
      result_reg      <= result_next;
      crs_reg         <= crs_next;
      tick_reg        <= tick_next;
      applied_delay   <= app_next;
      rdata           <= rd_next;
      sync_cal_enable <= en_next;
    end
  end

  // checks
  sequence s_ramp_wait;
    ramp_reg == 2'h1 && crs_reg != tgt && tick_reg == 9'(RAMP_CYC - 1);
  endsequence

  sequence s_ramp_fast_due;
    ramp_reg == 2'h3 && crs_reg != tgt && tick_reg == 9'(RAMP_CYC - 1);
  endsequence

  // between interval ends the coarse code must sit still
  sequence s_ramp_idle;
    ramp_reg[0] && tick_reg != 9'(RAMP_CYC - 1);
  endsequence

  // a finish seen while the enable is held across the edge
  sequence s_cal_event;
    en_reg && en_next && cal_finished;
  endsequence

  // calibration status flag
  chk_done_needs_en: assert property (@(posedge clock) disable iff (!rstn) // see RULE1
    done_reg |-> en_reg) else $error("done set while calibration disabled");
  chk_done_set: assert property (@(posedge clock) disable iff (!rstn) // see RULE1
    s_cal_event |=> done_reg) else $error("done not set on finish");
  chk_done_clear: assert property (@(posedge clock) disable iff (!rstn) // see RULE1
    !en_next |=> !done_reg) else $error("done kept after disable");
  // status read and result word layout
  chk_status_layout: assert property (@(posedge clock) disable iff (!rstn) // see RULE2
    req.rd && req.addr == sda_pkg::SDA_ADDR_CAL_STATUS |=>
    rdata == {6'h00, $past(done_reg), $past(result_reg)})
    else $error("status read layout wrong");
  chk_result_inv: assert property (@(posedge clock) disable iff (!rstn) // see RULE3
    en_reg && done_reg && $stable(done_reg) |=>
    applied_delay.invert == $past(result_reg[sda_pkg::SDA_INV_BIT]))
    else $error("invert not from result");
  chk_result_fields: assert property (@(posedge clock) disable iff (!rstn) // see RULE4
    s_cal_event |=>
    result_reg[sda_pkg::SDA_CRS_LSB +: sda_pkg::SDA_CRS_W] == $past(cal_result.coarse) &&
    result_reg[sda_pkg::SDA_FINE_W-1:0] == $past(cal_result.fine))
    else $error("result fields misplaced");
  // manual path
  chk_manual_inv: assert property (@(posedge clock) disable iff (!rstn) // see RULE5
    !en_reg |=> applied_delay.invert == $past(ctrl_reg[sda_pkg::SDA_INV_BIT]))
    else $error("manual invert not applied");
  chk_coarse_abrupt: assert property (@(posedge clock) disable iff (!rstn) // see RULE6
    !ramp_reg[0] |=> crs_reg == $past(tgt)) else $error("coarse did not follow write");
  chk_manual_coarse: assert property (@(posedge clock) disable iff (!rstn) // see RULE6
    !en_reg && !en_next && ramp_reg == 2'h0 && $stable(ctrl_reg) |=>
    ##1 applied_delay.coarse == $past(tgt, 2))
    else $error("manual coarse not applied");
  chk_fine_now: assert property (@(posedge clock) disable iff (!rstn) // see RULE7 see RULE11
    req.wr && req.addr == sda_pkg::SDA_ADDR_DELAY_CTRL && !en_next && !en_reg |=> ##1
    applied_delay.fine == $past(req.wdata[7:0], 2))
    else $error("fine write not immediate");
  // coarse ramp pacing and step size
  chk_ramp_slow: assert property (@(posedge clock) disable iff (!rstn) // see RULE14
    s_ramp_wait |=> (crs_reg == $past(crs_reg) + 8'h01) || (crs_reg == $past(crs_reg) - 8'h01))
    else $error("slow ramp step wrong");
  chk_ramp_fast: assert property (@(posedge clock) disable iff (!rstn) // see RULE14
    s_ramp_fast_due |=> crs_reg == $past(tgt) ||
    crs_reg == 8'($past(crs_reg) + sda_pkg::SDA_RAMP_FAST) ||
    crs_reg == 8'($past(crs_reg) - sda_pkg::SDA_RAMP_FAST))
    else $error("fast ramp step wrong");
  chk_ramp_hold: assert property (@(posedge clock) disable iff (!rstn) // see RULE14
    s_ramp_idle |=> $stable(crs_reg)) else $error("coarse moved between ramp ticks");
  // interval counter never passes the last tick
  chk_tick_bound: assert property (@(posedge clock) disable iff (!rstn) // see RULE14
    tick_reg < 9'(RAMP_CYC)) else $error("ramp tick out of range");
  // reserved bits and register reads
  chk_reserved_zero: assert property (@(posedge clock) disable iff (!rstn) // see RULE15
    (ctrl_reg & ~sda_pkg::SDA_CTRL_MASK) == 24'h000000) else $error("reserved bits stored");
  chk_rdata_idle: assert property (@(posedge clock) disable iff (!rstn) // see RULE15
    !req.rd |=> rdata == 24'h000000) else $error("read data without a read");
  chk_enable_read: assert property (@(posedge clock) disable iff (!rstn) // see RULE15
    req.rd && req.addr == sda_pkg::SDA_ADDR_CAL_ENABLE |=>
    rdata == {23'h000000, $past(en_reg)}) else $error("enable read wrong");
  // calibration overrides the manual word
  chk_cal_override: assert property (@(posedge clock) disable iff (!rstn) // see RULE13
    en_reg |=> applied_delay == $past(result_reg)) else $error("manual used in cal");
endmodule : sda_regs
`default_nettype wire

/* src/sda_pkg.sv */
`default_nettype none
package sda_pkg;
  // register indices as printed (byte-wide spi map)
  localparam logic [11:0] SDA_ADDR_DELAY_CTRL = 12'h2B5;
  localparam logic [11:0] SDA_ADDR_CAL_STATUS = 12'h2B2;
  localparam logic [11:0] SDA_ADDR_CAL_ENABLE = 12'h2B0;
  localparam logic [11:0] SDA_ADDR_RAMP_CTRL  = 12'h2B8;
  // delay word field layout
  localparam int SDA_INV_BIT   = 16;
  localparam int SDA_CRS_LSB   = 8;
  localparam int SDA_CRS_W     = 8;
  localparam int SDA_FINE_W    = 8;
  localparam int SDA_DONE_BIT  = 17;
  localparam int SDA_WORD_W    = 17;
  localparam logic [23:0] SDA_CTRL_MASK = 24'h01FFFF;
  localparam logic [23:0] SDA_STAT_MASK = 24'h03FFFF;
  localparam logic [23:0] SDA_CTRL_RST  = 24'h000000;
  // ramp rate: cycles per step interval, codes per step
  localparam int SDA_RAMP_STEP_CYC = 384;
  localparam logic [7:0] SDA_RAMP_SLOW = 8'h01;
  localparam logic [7:0] SDA_RAMP_FAST = 8'h04;
  // applied delay word
  typedef struct packed {
    logic       invert;
    logic [7:0] coarse;
    logic [7:0] fine;
  } sda_delay_t;
  // register access strobe group
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [23:0] wdata;
  } sda_req_t;
endpackage : sda_pkg
`default_nettype wire

/* dv/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // design stimulus and responses
  logic                clock = 1'b0;
  logic                rstn = 1'b0;
  sda_pkg::sda_req_t   req = '0;
  logic [23:0]         rdata;
  logic                cal_finished = 1'b0;
  sda_pkg::sda_delay_t cal_result = '0;
  sda_pkg::sda_delay_t applied_delay;
  logic                sync_cal_enable;
  int                  miscompares = 0;
  int                  checks_done = 0;
  // short ramp interval keeps the run brief; expectations use the same figure
  localparam int RC = 8;
  sda_regs #(.RAMP_CYC(RC)) u_sda_regs (.clock(clock), .rstn(rstn), .req(req), .rdata(rdata),
    .cal_finished(cal_finished), .cal_result(cal_result), .applied_delay(applied_delay),
    .sync_cal_enable(sync_cal_enable));
  // free-running 100 MHz clock
  always #5 clock = ~clock;
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // strobes rise and fall on falling edges so the rising edge sees them settled
  task wr(input logic [11:0] a, input logic [23:0] d);
    @(negedge clock); req.wr = 1'b1; req.addr = a; req.wdata = d;
    @(negedge clock); req.wr = 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [23:0] exp, input string what);
    @(negedge clock); req.rd = 1'b1; req.addr = a;
    @(negedge clock); req.rd = 1'b0;
    chk(what, exp, rdata);
  endtask : rd
  // bounded wait on the applied word; running out ends the run
  task wdly(input logic [16:0] exp, input int n, input string what);
    int i;
    for (i = 0; i < n && applied_delay !== exp; i++) @(negedge clock);
    chk(what, {7'h00, exp}, {7'h00, applied_delay});
    if (applied_delay !== exp) end_sim();
  endtask : wdly
  task t_reset;
    chk("applied at reset", 24'h000000, {7'h00, applied_delay});
    rd(sda_pkg::SDA_ADDR_DELAY_CTRL, 24'h000000, "ctrl reset");
    rd(sda_pkg::SDA_ADDR_CAL_STATUS, 24'h000000, "status reset");
    $display("test reset done");
  endtask : t_reset
  task t_manual;
    wr(sda_pkg::SDA_ADDR_DELAY_CTRL, 24'hFE1234);
    wdly(17'h01234, 4, "manual coarse fine");
    rd(sda_pkg::SDA_ADDR_DELAY_CTRL, 24'h001234, "ctrl reserved");
    wr(sda_pkg::SDA_ADDR_DELAY_CTRL, 24'h0112FF);
    wdly(17'h112FF, 4, "invert and fine");
    wr(sda_pkg::SDA_ADDR_DELAY_CTRL, 24'h001200);
    wdly(17'h01200, 4, "fine to zero");
    $display("test manual done");
  endtask : t_manual
  task t_cal;
    wr(sda_pkg::SDA_ADDR_CAL_ENABLE, 24'h000001);
    chk("enable out", 24'h1, {23'h0, sync_cal_enable});
    rd(sda_pkg::SDA_ADDR_CAL_STATUS, 24'h000000, "not done yet");
    rd(sda_pkg::SDA_ADDR_CAL_ENABLE, 24'h000001, "enable readback");
    @(negedge clock); cal_result = 17'h155AA; cal_finished = 1'b1;
    @(negedge clock); cal_finished = 1'b0; cal_result = 17'h0A5A5;
    rd(sda_pkg::SDA_ADDR_CAL_STATUS, 24'h0355AA, "done and result");
    wdly(17'h155AA, 4, "cal overrides");
    wr(sda_pkg::SDA_ADDR_DELAY_CTRL, 24'h004321);
    repeat (4) @(negedge clock);
    chk("manual ignored", 24'h0155AA, {7'h00, applied_delay});
    wr(sda_pkg::SDA_ADDR_CAL_ENABLE, 24'h000000);
    chk("enable off", 24'h000000, {23'h0, sync_cal_enable});
    // result field keeps the last calibration; done low marks it stale
    rd(sda_pkg::SDA_ADDR_CAL_STATUS, 24'h0155AA, "done off");
    wdly(17'h04321, 4, "manual back");
    $display("test cal done");
  endtask : t_cal
  task t_ramp;
    int n;
    wr(sda_pkg::SDA_ADDR_RAMP_CTRL, 24'h000001);
    wr(sda_pkg::SDA_ADDR_DELAY_CTRL, 24'h004521);
    wdly(17'h04421, RC + 4, "slow first step");
    for (n = 0; n < RC + 4 && applied_delay !== 17'h04521; n++) @(negedge clock);
    chk("slow step spacing", 24'(RC), 24'(n));
    wr(sda_pkg::SDA_ADDR_RAMP_CTRL, 24'h000003);
    wr(sda_pkg::SDA_ADDR_DELAY_CTRL, 24'h003D21);
    wdly(17'h04121, RC + 4, "fast step");
    wdly(17'h03D21, RC + 4, "fast target");
    rd(sda_pkg::SDA_ADDR_RAMP_CTRL, 24'h000003, "ramp readback");
    $display("test ramp done");
  endtask : t_ramp
  task t_refuse;
    wr(sda_pkg::SDA_ADDR_CAL_STATUS, 24'hFFFFFF);
    rd(sda_pkg::SDA_ADDR_CAL_STATUS, 24'h0155AA, "status read only");
    rd(12'h2B3, 24'h000000, "unmapped read");
    wr(12'h2B3, 24'hFFFFFF);
    rd(sda_pkg::SDA_ADDR_DELAY_CTRL, 24'h003D21, "unmapped write ignored");
    $display("test refuse done");
  endtask : t_refuse
  // main sequence: reset held for 16 cycles, released on a falling edge
  initial begin
    repeat (16) @(negedge clock);
    rstn = 1'b1;
    t_reset();
    t_manual();
    t_cal();
    t_ramp();
    t_refuse();
    end_sim();
  end
endmodule : tb
`default_nettype wire
